// [hw/ioxp_pkg.sv]
// Shared constants, types and decode helpers for the sixteen-line I/O expander
package ioxp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register codes held in the command pointer
  localparam logic [2:0] REG_LEVEL_LO  = 3'h0;
  localparam logic [2:0] REG_LEVEL_HI  = 3'h1;
  localparam logic [2:0] REG_DRIVE_LO  = 3'h2;
  localparam logic [2:0] REG_DRIVE_HI  = 3'h3;
  localparam logic [2:0] REG_INVERT_LO = 3'h4;
  localparam logic [2:0] REG_INVERT_HI = 3'h5;
  localparam logic [2:0] REG_DIR_LO    = 3'h6;
  localparam logic [2:0] REG_DIR_HI    = 3'h7;

  // Register pair groups, code bits 2:1
  localparam logic [1:0] GRP_LEVEL     = 2'h0;
  localparam logic [1:0] GRP_DRIVE     = 2'h1;
  localparam logic [1:0] GRP_INVERT    = 2'h2;
  localparam logic [1:0] GRP_DIR       = 2'h3;

  // Reset values
  localparam logic [7:0] DRIVE_RST     = 8'hff;
  localparam logic [7:0] INVERT_RST    = 8'h00;
  localparam logic [7:0] DIR_RST       = 8'hff;
  localparam logic [7:0] PTR_RST       = 8'h00;

  // Address byte layout
  localparam int         ADDR_RW_BIT   = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Timing: core rate and fast-mode serial limit
  localparam int         CORE_CLK_HZ   = 100_000_000;
  localparam int         FAST_MODE_HZ  = 400_000;
  localparam int         SCL_PERIOD_CYC = CORE_CLK_HZ / FAST_MODE_HZ;
  localparam logic [1:0] INIT_CYCLES   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    logic [15:0] drive;
    logic [15:0] invert;
    logic [15:0] dir;
  } ioxp_cfg_t;

  typedef enum logic [3:0]
  {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h2,
    ST_CMD       = 4'h3,
    ST_CMD_ACK   = 4'h4,
    ST_WDATA     = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA     = 4'h7,
    ST_RDATA_ACK = 4'h8
  } ioxp_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Only the low three command bits pick a register
  function automatic logic [2:0] ioxp_reg_sel(input logic [7:0] cmd);
    return cmd[2:0];
  endfunction

  function automatic logic [1:0] ioxp_reg_grp(input logic [7:0] cmd);
    return cmd[2:1];
  endfunction

endpackage

// [hw/ioxp_sync.sv]
// Two-stage synchroniser for pins arriving from outside the core clock
`timescale 1ns/1ps
module ioxp_sync
  import ioxp_pkg::*;
#(
  parameter int          W       = 1,
  parameter logic [15:0] RST_VAL = 16'h0000
)
(
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_b_in,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds the second only
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= W'(RST_VAL);
      sync_out <= W'(RST_VAL);
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// [hw/ioxp_regs.sv]
// Register bank: drive latches, inversion and direction, and the byte read mux
`timescale 1ns/1ps
module ioxp_regs
  import ioxp_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  // Write port
  input  wire logic        wr_en_in,
  input  wire logic [7:0]  wr_ptr_in,
  input  wire logic [7:0]  wr_data_in,
  // Read port
  input  wire logic [7:0]  rd_ptr_in,
  input  wire logic [15:0] level_in,
  output logic      [7:0]  rd_data_out,
  // Configuration
  output ioxp_cfg_t        cfg_out
);

  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [3:0] wr_lane;
  logic [3:0] rd_lane;

  assign wr_sel  = ioxp_reg_sel(wr_ptr_in);
  assign rd_sel  = ioxp_reg_sel(rd_ptr_in);
  assign wr_lane = {wr_sel[0], 3'h0};
  assign rd_lane = {rd_sel[0], 3'h0};

  ////////////////////////////////////////////////////////////////////////////
  // Level group has no storage here, so writes to it fall away
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cfg_out.drive  <= {DRIVE_RST, DRIVE_RST};
      cfg_out.invert <= {INVERT_RST, INVERT_RST};
      cfg_out.dir    <= {DIR_RST, DIR_RST};
    end
    else if (wr_en_in)
    begin
      case (ioxp_reg_grp(wr_ptr_in))
        GRP_DRIVE:  cfg_out.drive[wr_lane +: 8]  <= wr_data_in;
        GRP_INVERT: cfg_out.invert[wr_lane +: 8] <= wr_data_in;
        GRP_DIR:    cfg_out.dir[wr_lane +: 8]    <= wr_data_in;
        default:    ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Even codes use bits 7:0, odd codes bits 15:8
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rd_data_out <= 8'h00;
    else
    begin
      case (ioxp_reg_grp(rd_ptr_in))
        GRP_LEVEL:  rd_data_out <= level_in[rd_lane +: 8];
        GRP_DRIVE:  rd_data_out <= cfg_out.drive[rd_lane +: 8];
        GRP_INVERT: rd_data_out <= cfg_out.invert[rd_lane +: 8];
        default:    rd_data_out <= cfg_out.dir[rd_lane +: 8];
      endcase
    end
  end

  a_level_write_drop : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_en_in && ioxp_reg_grp(wr_ptr_in) == GRP_LEVEL) |=> $stable(cfg_out))
    else $error("Write to a level register changed configuration");

endmodule

// [hw/ioxp_top.sv]
// Sixteen-line two-wire serial I/O expander: bus slave, pointer, ports, interrupt
`timescale 1ns/1ps
module ioxp_top
  import ioxp_pkg::*;
#(
  parameter logic [3:0] ADDR_FIXED = 4'h4
)
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       rst_b_in,
  // Address straps
  input  wire logic       addr_strap_bit0_in,
  input  wire logic       addr_strap_bit1_in,
  input  wire logic       addr_strap_bit2_in,
  // Serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  // Low port pins
  input  wire logic [7:0] lo_port_pin_in,
  output logic      [7:0] lo_port_pin_out,
  output logic      [7:0] lo_port_pin_oe_out,
  // High port pins
  input  wire logic [7:0] hi_port_pin_in,
  output logic      [7:0] hi_port_pin_out,
  output logic      [7:0] hi_port_pin_oe_out,
  // Interrupt, open drain
  output logic            int_b_out,
  output logic            int_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs
  logic        scl_s;
  logic        sda_s;
  logic [2:0]  strap_s;
  logic [15:0] pins_s;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;

  // Bus machine
  ioxp_state_t state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  ptr_reg;
  logic        master_ack_reg;
  logic        addr_match;
  logic        byte_done;

  // Register bank links
  ioxp_cfg_t   cfg;
  logic [15:0] level;
  logic [7:0]  rd_data;
  logic        wr_en;

  // Interrupt tracking
  logic [15:0] snap_reg;
  logic [1:0]  init_cnt_reg;
  logic        int_act;

  ////////////////////////////////////////////////////////////////////////////
  // SCL and SDA sampled at 100 MHz; fast-mode gives SCL_PERIOD_CYC samples a bit
  ioxp_sync #(.W(2), .RST_VAL(16'h0003)) u_bus_sync
  (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    ({scl_in, sda_in}),
    .sync_out    ({scl_s, sda_s})
  );

  ioxp_sync #(.W(19), .RST_VAL(16'h0000)) u_pin_sync
  (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .async_in    ({addr_strap_bit2_in, addr_strap_bit1_in, addr_strap_bit0_in,
                   hi_port_pin_in, lo_port_pin_in}),
    .sync_out    ({strap_s, pins_s})
  );

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_prev_reg;
  assign scl_fall   = ~scl_s & scl_prev_reg;
  assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign byte_done  = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);

  // Upper bits fixed, lower three from straps
  assign addr_match = (shift_reg[7:1] == {ADDR_FIXED, strap_s});

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine; a start wins from any state, a stop idles it
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      state_reg <= ST_IDLE;
    else if (start_cond)
      state_reg <= ST_ADDR;
    else if (stop_cond)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_ADDR:
          if (byte_done)
            state_reg <= addr_match ? ST_ADDR_ACK : ST_IDLE;
        ST_ADDR_ACK:
          if (scl_fall)
            state_reg <= shift_reg[ADDR_RW_BIT] ? ST_RDATA : ST_CMD;
        ST_CMD:
          if (byte_done)
            state_reg <= ST_CMD_ACK;
        ST_CMD_ACK:
          if (scl_fall)
            state_reg <= ST_WDATA;
        ST_WDATA:
          if (byte_done)
            state_reg <= ST_WDATA_ACK;
        ST_WDATA_ACK:
          if (scl_fall)
            state_reg <= ST_WDATA;
        ST_RDATA:
          if (byte_done)
            state_reg <= ST_RDATA_ACK;
        ST_RDATA_ACK:
          if (scl_fall)
            state_reg <= master_ack_reg ? ST_RDATA : ST_IDLE;
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
    end
    else if (start_cond || byte_done || (scl_fall && !(state_reg inside {ST_ADDR, ST_CMD,
                                                                         ST_WDATA, ST_RDATA})))
      bit_cnt_reg <= 4'h0;
    // Ack bits stay out of the shifter, so the direction bit survives the ack
    else if (scl_rise && bit_cnt_reg != BITS_PER_BYTE && state_reg inside {ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA})
    begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      shift_reg   <= {shift_reg[6:0], sda_s};
    end
  end

  // Master acknowledge sampled on the ninth rising edge of a read byte
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      master_ack_reg <= 1'b0;
    else if (state_reg == ST_RDATA_ACK && scl_rise)
      master_ack_reg <= ~sda_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer: loaded only by a command byte, low bit flipped after each data byte; untouched by stop or restart
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ptr_reg <= PTR_RST;
    else if (state_reg == ST_CMD && byte_done)
      ptr_reg <= shift_reg;
    else if ((state_reg == ST_WDATA_ACK && scl_fall) || (state_reg == ST_RDATA_ACK && scl_rise))
      ptr_reg <= {ptr_reg[7:1], ~ptr_reg[0]};
  end

  assign wr_en = (state_reg == ST_WDATA) && byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter, loaded as a read byte begins
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tx_reg <= 8'hff;
    else if (scl_fall && ((state_reg == ST_ADDR_ACK && shift_reg[ADDR_RW_BIT])
                          || (state_reg == ST_RDATA_ACK && master_ack_reg)))
      tx_reg <= rd_data;
    else if (state_reg == ST_RDATA && scl_fall)
      tx_reg <= {tx_reg[6:0], 1'b1};
  end

  // Open drain data: only ever pulls low; acks only after our own address
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sda_oe_out <= 1'b0;
    else if (start_cond || stop_cond)
      sda_oe_out <= 1'b0;
    else if (scl_fall)
    begin
      case (state_reg)
        ST_ADDR:      sda_oe_out <= byte_done && addr_match;
        ST_CMD:       sda_oe_out <= byte_done;
        ST_WDATA:     sda_oe_out <= byte_done;
        ST_ADDR_ACK:  sda_oe_out <= shift_reg[ADDR_RW_BIT] && !rd_data[7];
        ST_RDATA:     sda_oe_out <= !byte_done && !tx_reg[6];
        ST_RDATA_ACK: sda_oe_out <= master_ack_reg && !rd_data[7];
        default:      sda_oe_out <= 1'b0;
      endcase
    end
  end

  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  assign level = pins_s ^ (cfg.invert & cfg.dir);

  ioxp_regs u_regs
  (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .wr_en_in    (wr_en),
    .wr_ptr_in   (ptr_reg),
    .wr_data_in  (shift_reg),
    .rd_ptr_in   (ptr_reg),
    .level_in    (level),
    .rd_data_out (rd_data),
    .cfg_out     (cfg)
  );

  // Pin drivers
  assign lo_port_pin_out    = cfg.drive[7:0];
  assign hi_port_pin_out    = cfg.drive[15:8];
  assign lo_port_pin_oe_out = ~cfg.dir[7:0];
  assign hi_port_pin_oe_out = ~cfg.dir[15:8];

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot of pins, first caught once the synchroniser has settled after reset
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      init_cnt_reg <= 2'h0;
    else if (init_cnt_reg != INIT_CYCLES)
      init_cnt_reg <= init_cnt_reg + 2'h1;
  end

  // Recapture at the ack edge of a level read; a change during that edge may be missed
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      snap_reg <= 16'h0000;
    else if (init_cnt_reg != INIT_CYCLES)
      snap_reg <= pins_s;
    else if (state_reg == ST_RDATA_ACK && scl_rise && ioxp_reg_grp(ptr_reg) == GRP_LEVEL)
    begin
      if (ptr_reg[0])
        snap_reg[15:8] <= pins_s[15:8];
      else
        snap_reg[7:0] <= pins_s[7:0];
    end
  end

  // Only input pins compare; returning to the snapshot releases it
  assign int_act = |((pins_s ^ snap_reg) & cfg.dir);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      int_oe_out <= 1'b0;
    else
      int_oe_out <= int_act && (init_cnt_reg == INIT_CYCLES);
  end

  assign int_b_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  a_addr_ack_low : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_reg == ST_ADDR && byte_done && addr_match && !start_cond && !stop_cond)
      |=> (state_reg == ST_ADDR_ACK) && sda_oe_out)
    else $error("Own address not acknowledged");

  a_foreign_addr : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_reg == ST_ADDR && byte_done && !addr_match && !start_cond && !stop_cond)
      |=> (state_reg == ST_IDLE) && !sda_oe_out)
    else $error("Foreign address was answered");

  a_rw_select : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_reg == ST_ADDR_ACK && scl_fall && !start_cond && !stop_cond)
      |=> (state_reg == (shift_reg[ADDR_RW_BIT] ? ST_RDATA : ST_CMD)))
    else $error("Direction bit misread");

  a_cmd_store : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_reg == ST_CMD && byte_done && !start_cond && !stop_cond)
      |=> (ptr_reg == $past(shift_reg)) && (state_reg == ST_CMD_ACK))
    else $error("Command byte not stored in pointer");

  a_ptr_pair_flip : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (state_reg == ST_WDATA_ACK && scl_fall)
      |=> (ptr_reg[0] != $past(ptr_reg[0])) && (ptr_reg[7:1] == $past(ptr_reg[7:1])))
    else $error("Pointer did not move to the pair partner");

  a_ptr_keep_stop : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (stop_cond || start_cond) |=> $stable(ptr_reg))
    else $error("Pointer changed on stop or start");

  a_pin_drive : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    wr_en && ioxp_reg_grp(ptr_reg) == GRP_DRIVE
      |=> ##1 (ptr_reg[0] ? hi_port_pin_out : lo_port_pin_out) == $past(shift_reg, 2))
    else $error("Drive latch write did not reach the pins");

  a_output_no_int : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    int_oe_out |-> |(($past(pins_s) ^ $past(snap_reg)) & $past(cfg.dir)))
    else $error("Interrupt raised without a changed input pin");

  a_int_raise : assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (int_act && init_cnt_reg == INIT_CYCLES) |=> int_oe_out)
    else $error("Changed input pin did not raise the interrupt");

endmodule

// [dv/ioxp_master.sv]
// Behavioural two-wire bus master that drives the expander's serial pins
`timescale 1ns/1ps
module ioxp_master
(
  // Clock
  input  wire logic core_clk_in,
  // Serial bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  logic [7:0] rd_data;
  event       rd_done;

  // Clock stands high and data released between frames
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  // Data moves 5 cycles into the low phase, past the slave's 3-cycle answer
  task automatic bit_cycle(input logic b, output logic s);
    tick(5);
    sda_low_out <= ~b;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    s = sda_in;
    tick(4);
    scl_out <= 1'b0;
  endtask

  // Also serves as repeated start: release, raise clock, then pull data low
  task automatic start();
    tick(5);
    sda_low_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b1;
    tick(4);
    scl_out <= 1'b0;
  endtask

  task automatic stop();
    tick(5);
    sda_low_out <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_low_out <= 1'b0;
    tick(8);
  endtask

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask

  // Last byte of a read is refused by the master
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b1, d[i]);
    rd_data = d;
    bit_cycle(~ack, s);
    -> rd_done;
  endtask
endmodule

// [dv/ioxp_top_bench.sv]
// Self-checking bench for the I/O expander: registers, pins, addressing, interrupt
`timescale 1ns/1ps
module ioxp_top_bench
  import ioxp_pkg::*;
;
  localparam logic [3:0] ADDR_HI = 4'h9;
  logic       core_clk, rst_b, scl, sda_low, dut_sda, dut_sda_oe, int_b, int_oe, ack;
  wire        sda;
  logic [2:0] strap, ptr;
  logic [7:0] lo_ext, hi_ext, lo_out, lo_oe, hi_out, hi_oe, d;
  wire  [7:0] lo_pin, hi_pin;
  logic [7:0] mdl [8];
  logic [7:0] exp_q [$];
  int         fail_count, check_count, seed;

  // Open-drain bus with pull-up; pins resolved from driver enables
  assign sda    = ~((dut_sda_oe & ~dut_sda) | sda_low);
  assign lo_pin = (lo_oe & lo_out) | (~lo_oe & lo_ext);
  assign hi_pin = (hi_oe & hi_out) | (~hi_oe & hi_ext);

  ioxp_top #(.ADDR_FIXED(ADDR_HI)) u_dut
  (
    .core_clk_in(core_clk), .rst_b_in(rst_b),
    .addr_strap_bit0_in(strap[0]), .addr_strap_bit1_in(strap[1]), .addr_strap_bit2_in(strap[2]),
    .scl_in(scl), .sda_in(sda), .sda_out(dut_sda), .sda_oe_out(dut_sda_oe),
    .lo_port_pin_in(lo_pin), .lo_port_pin_out(lo_out), .lo_port_pin_oe_out(lo_oe),
    .hi_port_pin_in(hi_pin), .hi_port_pin_out(hi_out), .hi_port_pin_oe_out(hi_oe),
    .int_b_out(int_b), .int_oe_out(int_oe)
  );

  ioxp_master u_master
  (
    .core_clk_in(core_clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    check_byte("reset low enable", 8'h00, lo_oe);
    check_byte("reset high drive", 8'hff, hi_out);
    rst_b <= 1'b1;
    mdl = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
    ptr = 3'h0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic addr(input logic [7:0] a, input logic exp);
    u_master.start();
    u_master.wr_byte(a, ack);
    check_flag("address ack", exp, ack);
  endtask

  // Command then up to two data bytes; pins checked once the latches land
  task automatic wr(input logic [7:0] cmd, input int n, input logic [15:0] data);
    addr({ADDR_HI, strap, 1'b0}, 1'b1);
    u_master.wr_byte(cmd, ack);
    check_flag("command ack", 1'b1, ack);
    ptr = cmd[2:0];
    for (int i = 0; i < n; i++)
    begin
      u_master.wr_byte(data[8*i +: 8], ack);
      check_flag("data ack", 1'b1, ack);
      if (ptr[2:1] != 2'h0)
        mdl[ptr] = data[8*i +: 8];
      ptr[0] = ~ptr[0];
    end
    u_master.stop();
    repeat (6) @(posedge core_clk);
    check_byte("low drive", mdl[2], lo_out);
    check_byte("high drive", mdl[3], hi_out);
    check_byte("low enable", ~mdl[6], lo_oe);
    check_byte("high enable", ~mdl[7], hi_oe);
  endtask

  // Levels read back raw, flipped only on inverted input pins
  task automatic rd(input int n);
    logic [7:0] pin;
    addr({ADDR_HI, strap, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      pin = ptr[0] ? hi_pin : lo_pin;
      exp_q.push_back(ptr[2:1] == 2'h0 ? pin ^ (mdl[4 + ptr[0]] & mdl[6 + ptr[0]]) : mdl[ptr]);
      u_master.rd_byte(i < n - 1, d);
      ptr[0] = ~ptr[0];
    end
    u_master.stop();
  endtask

  task automatic reset_values();
    for (int c = 2; c < 8; c += 2)
    begin
      wr(8'(c), 0, 16'h0000);
      rd(2);
    end
  endtask

  task automatic int_step(input string what, input logic exp);
    repeat (8) @(posedge core_clk);
    check_flag(what, exp, int_oe);
    check_flag("interrupt drive level", 1'b0, int_b);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  forever
  begin
    @(u_master.rd_done);
    check_byte("read data", exp_q.pop_front(), u_master.rd_data);
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    $display("BAD watchdog expected finish seen hang");
    end_of_test();
  end

  initial
  begin
    rst_b = 1'b0;
    strap = 3'h0;
    lo_ext = 8'h5a;
    hi_ext = 8'hc3;
    seed = 35;
    fail_count = 0;
    check_count = 0;
    do_reset();
    reset_values();
    $display("test reset_values done");
    for (int k = 0; k < 8; k++)
    begin
      lo_ext <= 8'($random(seed));
      hi_ext <= 8'($random(seed));
      wr({5'($random(seed)), 3'(k)}, 2, 16'($random(seed)));
      rd(1);
      rd(2);
    end
    $display("test register_access done");
    for (int s = 0; s < 8; s++)
    begin
      strap <= s[2:0];
      repeat (4) @(posedge core_clk);
      addr({ADDR_HI, s[2:0], 1'b0}, 1'b1);
      u_master.stop();
      addr({ADDR_HI, s[2:0] ^ 3'h5, 1'b0}, 1'b0);
      u_master.stop();
    end
    addr({ADDR_HI ^ 4'h2, strap, 1'b1}, 1'b0);
    u_master.stop();
    $display("test addressing done");
    wr(8'h06, 2, 16'hffff);
    wr(8'h00, 0, 16'h0000);
    rd(2);
    int_step("interrupt idle", 1'b0);
    lo_ext[5] <= ~lo_ext[5];
    int_step("interrupt on change", 1'b1);
    lo_ext[5] <= ~lo_ext[5];
    int_step("interrupt on return", 1'b0);
    hi_ext[2] <= ~hi_ext[2];
    int_step("interrupt high port", 1'b1);
    wr(8'h01, 0, 16'h0000);
    rd(1);
    int_step("interrupt after read", 1'b0);
    wr(8'h02, 1, {8'h00, ~lo_ext});
    wr(8'h06, 1, 16'h00fe);
    lo_ext[0] <= ~lo_ext[0];
    int_step("interrupt from output", 1'b0);
    $display("test interrupt done");
    do_reset();
    reset_values();
    $display("test second_reset done");
    end_of_test();
  end
endmodule
